// ===== iotg_top.sv
`timescale 1ns/1ps
`default_nettype none
module iotg_top
  import iotg_pkg::*;
#(
  parameter bit                   AUTO_IO_STIMULUS_SELECT = 1'b1,
  parameter bit                   CONDENSED_IO            = 1'b0,
  parameter logic [15:0]          SUPPORTED_TYPES         = `IOTG_SUPPORTED,
  parameter int                   FIFO_DEPTH              = `IOTG_FIFO_DEPTH,
  parameter int                   MEM_IDX_W               = `IOTG_MEM_IDX_W
) (
  input  wire logic                    clock,
  input  wire logic                    rstn,
  // Separate initiator / target channels
  output var  logic                    ireqValid,
  input  wire logic                    ireqReady,
  output iotg_pkt_t                    ireq,
  input  wire logic                    irespValid,
  output var  logic                    irespReady,
  input  wire iotg_pkt_t               iresp,
  input  wire logic                    treqValid,
  output var  logic                    treqReady,
  input  wire iotg_pkt_t               treq,
  output var  logic                    trespValid,
  input  wire logic                    trespReady,
  output iotg_pkt_t                    tresp,
  // Condensed channels
  output var  logic                    iotxValid,
  input  wire logic                    iotxReady,
  output iotg_pkt_t                    iotx,
  input  wire logic                    iorxValid,
  output var  logic                    iorxReady,
  input  wire iotg_pkt_t               iorx,
  // External user side
  input  wire logic                    userIreqValid,
  output var  logic                    userIreqReady,
  input  wire iotg_pkt_t               userIreq,
  output var  logic                    userIrespValid,
  input  wire logic                    userIrespReady,
  output iotg_pkt_t                    userIresp,
  output var  logic                    userTreqValid,
  input  wire logic                    userTreqReady,
  output iotg_pkt_t                    userTreq,
  input  wire logic                    userTrespValid,
  output var  logic                    userTrespReady,
  input  wire iotg_pkt_t               userTresp,
  // Status
  output var  logic                    exerciseDone,
  output var  logic                    mismatch,
  output var  logic [`IOTG_MISS_W-1:0] mismatchCount
);
  localparam int PW = `IOTG_PEND_W;
  localparam int LW = $clog2(`IOTG_LIST_N);
  localparam int W  = $bits(iotg_pkt_t);

  // ----------------------------------------------------------------
  // FIFO handshakes
  // ----------------------------------------------------------------
  logic      txReqInValid,  txReqInReady,  txReqOutValid,  txReqOutReady;
  logic      txRspInValid,  txRspInReady,  txRspOutValid,  txRspOutReady;
  logic      rxRspInValid,  rxRspInReady,  rxRspOutValid,  rxRspOutReady;
  logic      rxReqInValid,  rxReqInReady,  rxReqOutValid,  rxReqOutReady;
  iotg_pkt_t txReqIn, txReqOut, txRspIn, txRspOut;
  iotg_pkt_t rxRspIn, rxRspOut, rxReqIn, rxReqOut;

  // ----------------------------------------------------------------
  // Request generator
  // ----------------------------------------------------------------
  logic [LW-1:0]          listIdx;
  logic                   listDone;
  logic [PW-1:0]          tidCount;
  logic [(1<<PW)-1:0]     pendValid;
  iotg_ttype_t            pendType [1<<PW];
  iotg_instr_t            curInstr;
  logic                   curSupported;
  logic                   curNeedsResp;
  logic                   genValid;
  logic                   genFire;
  logic                   listStep;
  iotg_pkt_t              genPkt;
  iotg_ttype_t            curExpect;

  assign curInstr     = IOTG_LIST[listIdx];
  assign curSupported = SUPPORTED_TYPES[curInstr.ttype];
  assign curNeedsResp = (curInstr.ttype == IOTG_NREAD) || (curInstr.ttype == IOTG_NWRITE_R)
                        || (curInstr.ttype == IOTG_DOORBELL);
  assign curExpect    = (curInstr.ttype == IOTG_NREAD) ? IOTG_RESP_DAT : IOTG_RESP_NOD;
  assign genValid     = !listDone && curSupported && !pendValid[tidCount];
  assign genFire      = genValid && txReqInReady;
  assign listStep     = !listDone && (!curSupported || genFire);
  assign genPkt       = '{ttype: curInstr.ttype, tid: `IOTG_TID_W'(tidCount), prio: curInstr.prio,
                           addr: curInstr.addr, data: curInstr.data};

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      listIdx  <= '0;
      listDone <= 1'b0;
      tidCount <= '0;
    end else begin
      if (listStep) begin
        listIdx  <= listIdx + LW'(1);
        listDone <= (listIdx == LW'(`IOTG_LIST_N - 1));
      end
      if (genFire) begin
        tidCount <= tidCount + PW'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Response checker
  // ----------------------------------------------------------------
  logic          chkFire;
  logic [PW-1:0] chkIdx;
  logic          chkBad;

  assign chkFire = AUTO_IO_STIMULUS_SELECT && rxRspOutValid;
  assign chkIdx  = rxRspOut.tid[PW-1:0];
  assign chkBad  = !pendValid[chkIdx] || (pendType[chkIdx] != rxRspOut.ttype)
                   || (rxRspOut.tid[`IOTG_TID_W-1:PW] != '0);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pendValid     <= '0;
      mismatch      <= 1'b0;
      mismatchCount <= '0;
      exerciseDone  <= 1'b0;
    end else begin
      for (int i = 0; i < (1<<PW); i++) begin
        if (AUTO_IO_STIMULUS_SELECT && genFire && curNeedsResp && tidCount == PW'(i)) begin
          pendValid[i] <= 1'b1;
        end else if (chkFire && chkIdx == PW'(i)) begin
          pendValid[i] <= 1'b0;
        end
      end
      if (chkFire && chkBad) begin
        mismatch      <= 1'b1;
        mismatchCount <= mismatchCount + `IOTG_MISS_W'(1);
      end
      exerciseDone <= AUTO_IO_STIMULUS_SELECT && listDone && (pendValid == '0);
    end
  end

  always_ff @(posedge clock) begin
    if (genFire) begin
      pendType[tidCount] <= curExpect;
    end
  end

  // ----------------------------------------------------------------
  // Target responder
  // ----------------------------------------------------------------
  logic [`IOTG_DATA_W-1:0] scratch [1<<MEM_IDX_W];
  logic [`IOTG_DATA_W-1:0] pattern;
  logic                    rqInWin;
  logic [MEM_IDX_W-1:0]    rqIdx;
  logic                    rqIsWrite;
  logic                    rqNeedsResp;
  logic                    rqTake;
  logic                    rqStore;
  logic                    rqPattern;
  iotg_pkt_t               rspPkt;

  assign rqInWin     = rxReqOut.addr[`IOTG_ADDR_W-1:`IOTG_WIN_LSB] == `IOTG_SCRATCH_HI;
  assign rqIdx       = rxReqOut.addr[`IOTG_WORD_LSB +: MEM_IDX_W];
  assign rqIsWrite   = (rxReqOut.ttype == IOTG_NWRITE) || (rxReqOut.ttype == IOTG_NWRITE_R)
                       || (rxReqOut.ttype == IOTG_SWRITE);
  assign rqNeedsResp = (rxReqOut.ttype == IOTG_NREAD) || (rxReqOut.ttype == IOTG_NWRITE_R)
                       || (rxReqOut.ttype == IOTG_DOORBELL);
  assign rqTake      = AUTO_IO_STIMULUS_SELECT && rxReqOutValid && (!rqNeedsResp || txRspInReady);
  assign rqStore     = rqTake && rqIsWrite && rqInWin;
  assign rqPattern   = rqTake && (rxReqOut.ttype == IOTG_NREAD) && !rqInWin;

  always_comb begin
    rspPkt      = '0;
    rspPkt.tid  = rxReqOut.tid;
    rspPkt.prio = (rxReqOut.prio == `IOTG_PRIO_MAX) ? `IOTG_PRIO_MAX
                  : rxReqOut.prio + `IOTG_PRIO_STEP;
    rspPkt.addr = rxReqOut.addr;
    if (rxReqOut.ttype == IOTG_NREAD) begin
      rspPkt.ttype = IOTG_RESP_DAT;
      rspPkt.data  = rqInWin ? scratch[rqIdx] : pattern;
    end else begin
      rspPkt.ttype = IOTG_RESP_NOD;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pattern <= '0;
    end else if (rqPattern) begin
      pattern <= pattern + `IOTG_DATA_W'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (rqStore) begin
      scratch[rqIdx] <= rxReqOut.data;
    end
  end

  // ----------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------
  assign txReqInValid   = AUTO_IO_STIMULUS_SELECT ? genValid : userIreqValid;
  assign txReqIn        = AUTO_IO_STIMULUS_SELECT ? genPkt : userIreq;
  assign txRspInValid   = AUTO_IO_STIMULUS_SELECT ? (rxReqOutValid && rqNeedsResp)
                                                  : userTrespValid;
  assign txRspIn        = AUTO_IO_STIMULUS_SELECT ? rspPkt : userTresp;
  assign rxRspOutReady  = AUTO_IO_STIMULUS_SELECT ? 1'b1 : userIrespReady;
  assign rxReqOutReady  = AUTO_IO_STIMULUS_SELECT ? rqTake : userTreqReady;
  assign userIreqReady  = !AUTO_IO_STIMULUS_SELECT && txReqInReady;
  assign userTrespReady = !AUTO_IO_STIMULUS_SELECT && txRspInReady;
  assign userIrespValid = !AUTO_IO_STIMULUS_SELECT && rxRspOutValid;
  assign userIresp      = rxRspOut;
  assign userTreqValid  = !AUTO_IO_STIMULUS_SELECT && rxReqOutValid;
  assign userTreq       = rxReqOut;

  // ----------------------------------------------------------------
  // Link side: separate or condensed channels
  // ----------------------------------------------------------------
  logic rxIsResp;
  assign rxIsResp = CONDENSED_IO ? iorx.ttype[`IOTG_TTYPE_W-1] : 1'b1;

  generate
    if (CONDENSED_IO) begin : gCondensed
      logic txSlotFree;
      assign txSlotFree    = !iotxValid || iotxReady;
      assign txRspOutReady = txSlotFree;
      assign txReqOutReady = txSlotFree && !txRspOutValid;
      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          iotxValid <= 1'b0;
          iotx      <= '0;
        end else if (txSlotFree) begin
          iotxValid <= txRspOutValid || txReqOutValid;
          iotx      <= txRspOutValid ? txRspOut : txReqOut;
        end
      end
      assign rxRspInValid = iorxValid && rxIsResp;
      assign rxReqInValid = iorxValid && !rxIsResp;
      assign rxRspIn      = iorx;
      assign rxReqIn      = iorx;
      assign iorxReady    = rxIsResp ? rxRspInReady : rxReqInReady;
      assign ireqValid    = 1'b0;
      assign ireq         = '0;
      assign trespValid   = 1'b0;
      assign tresp        = '0;
      assign irespReady   = 1'b0;
      assign treqReady    = 1'b0;
    end else begin : gSeparate
      assign ireqValid     = txReqOutValid;
      assign ireq          = txReqOut;
      assign txReqOutReady = ireqReady;
      assign trespValid    = txRspOutValid;
      assign tresp         = txRspOut;
      assign txRspOutReady = trespReady;
      assign rxRspInValid  = irespValid;
      assign rxRspIn       = iresp;
      assign irespReady    = rxRspInReady;
      assign rxReqInValid  = treqValid;
      assign rxReqIn       = treq;
      assign treqReady     = rxReqInReady;
      assign iotxValid     = 1'b0;
      assign iotx          = '0;
      assign iorxReady     = 1'b0;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Buffers
  // ----------------------------------------------------------------
  iotg_fifo #(.WIDTH(W), .DEPTH(FIFO_DEPTH)) uTxReq (
    .clock    (clock),
    .rstn     (rstn),
    .inValid  (txReqInValid),
    .inReady  (txReqInReady),
    .inData   (txReqIn),
    .outValid (txReqOutValid),
    .outReady (txReqOutReady),
    .outData  (txReqOut)
  );

  iotg_fifo #(.WIDTH(W), .DEPTH(FIFO_DEPTH)) uTxRsp (
    .clock    (clock),
    .rstn     (rstn),
    .inValid  (txRspInValid),
    .inReady  (txRspInReady),
    .inData   (txRspIn),
    .outValid (txRspOutValid),
    .outReady (txRspOutReady),
    .outData  (txRspOut)
  );

  iotg_fifo #(.WIDTH(W), .DEPTH(FIFO_DEPTH)) uRxRsp (
    .clock    (clock),
    .rstn     (rstn),
    .inValid  (rxRspInValid),
    .inReady  (rxRspInReady),
    .inData   (rxRspIn),
    .outValid (rxRspOutValid),
    .outReady (rxRspOutReady),
    .outData  (rxRspOut)
  );

  iotg_fifo #(.WIDTH(W), .DEPTH(FIFO_DEPTH)) uRxReq (
    .clock    (clock),
    .rstn     (rstn),
    .inValid  (rxReqInValid),
    .inReady  (rxReqInReady),
    .inData   (rxReqIn),
    .outValid (rxReqOutValid),
    .outReady (rxReqOutReady),
    .outData  (rxReqOut)
  );
endmodule
`default_nettype wire

// ===== iotg_regs.svh
// Behaviour
// - Requests come from a fixed list, issued in the same order every run.
// - Only transaction types enabled by the supported-type mask are issued.
// - Expected responses are recorded per request and returned ones compared.
// - Response checking runs only under automatic stimulus.
// - Write payloads addressed inside the scratch window are stored locally.
// - Writes outside the scratch window needing no response are dropped.
// - Streaming writes never produce a response.
// - Reads inside the scratch window return the stored local data.
// - Reads outside the scratch window return an incrementing pattern.
// - Responses leave in the order their requests arrived.
// - Response priority is request priority plus one, saturating at 3.
// - Selector 0 uses the external interfaces; 1 uses the internal generators.
// - Condensed mode adds an adapter merging requests and responses onto one channel per direction.
`ifndef IOTG_REGS_SVH
`define IOTG_REGS_SVH

`define IOTG_TTYPE_W      4
`define IOTG_TID_W        8
`define IOTG_PRIO_W       2
`define IOTG_ADDR_W       32
`define IOTG_DATA_W       64
`define IOTG_SCRATCH_HI   16'h0012
`define IOTG_WIN_LSB      16
`define IOTG_WORD_LSB     3
`define IOTG_PRIO_STEP    2'h1
`define IOTG_PRIO_MAX     2'h3
`define IOTG_PEND_W       4
`define IOTG_MEM_IDX_W    4
`define IOTG_FIFO_DEPTH   4
`define IOTG_LIST_N       8
`define IOTG_SUPPORTED    16'h001F
`define IOTG_MISS_W       8

`endif

// ===== iotg_pkg.sv
`include "iotg_regs.svh"
package iotg_pkg;

  typedef enum logic [`IOTG_TTYPE_W-1:0] {
    IOTG_NREAD    = 4'h0,
    IOTG_NWRITE   = 4'h1,
    IOTG_NWRITE_R = 4'h2,
    IOTG_SWRITE   = 4'h3,
    IOTG_DOORBELL = 4'h4,
    IOTG_RESP_NOD = 4'h8,
    IOTG_RESP_DAT = 4'h9
  } iotg_ttype_t;

  typedef struct packed {
    iotg_ttype_t               ttype;
    logic [`IOTG_TID_W-1:0]    tid;
    logic [`IOTG_PRIO_W-1:0]   prio;
    logic [`IOTG_ADDR_W-1:0]   addr;
    logic [`IOTG_DATA_W-1:0]   data;
  } iotg_pkt_t;

  typedef struct packed {
    iotg_ttype_t               ttype;
    logic [`IOTG_PRIO_W-1:0]   prio;
    logic [`IOTG_ADDR_W-1:0]   addr;
    logic [`IOTG_DATA_W-1:0]   data;
  } iotg_instr_t;

  typedef iotg_instr_t iotg_list_t [`IOTG_LIST_N];

  localparam iotg_list_t IOTG_LIST = '{
    '{IOTG_NWRITE_R, 2'h0, 32'h0012_0008, 64'h0123_4567_89AB_CDEF},
    '{IOTG_NREAD,    2'h1, 32'h0012_0008, 64'h0000_0000_0000_0000},
    '{IOTG_SWRITE,   2'h0, 32'h0012_0010, 64'hFEDC_BA98_7654_3210},
    '{IOTG_DOORBELL, 2'h2, 32'h0000_0000, 64'h0000_0000_0000_00A5},
    '{IOTG_NWRITE,   2'h1, 32'h0040_0000, 64'h5A5A_5A5A_5A5A_5A5A},
    '{IOTG_NREAD,    2'h0, 32'h0040_0020, 64'h0000_0000_0000_0000},
    '{IOTG_NREAD,    2'h2, 32'h0012_0010, 64'h0000_0000_0000_0000},
    '{IOTG_NWRITE_R, 2'h1, 32'h0012_0018, 64'h1111_2222_3333_4444}
  };

endpackage

// ===== iotg_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module iotg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic             inValid,
  output var  logic             inReady,
  input  wire logic [WIDTH-1:0] inData,
  output var  logic             outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wrPtr;
  logic [PW-1:0]    rdPtr;
  logic [PW:0]      count;
  logic [PW:0]      next_count;
  wire              push = inValid && inReady;
  wire              pop  = outValid && outReady;

  assign outData = mem[rdPtr];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + (PW+1)'(1);
    end else if (pop && !push) begin
      next_count = count - (PW+1)'(1);
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wrPtr    <= '0;
      rdPtr    <= '0;
      count    <= '0;
      inReady  <= 1'b0;
      outValid <= 1'b0;
    end else begin
      if (push) begin
        wrPtr <= (wrPtr == PW'(DEPTH-1)) ? '0 : wrPtr + PW'(1);
      end
      if (pop) begin
        rdPtr <= (rdPtr == PW'(DEPTH-1)) ? '0 : rdPtr + PW'(1);
      end
      count    <= next_count;
      inReady  <= (next_count != (PW+1)'(DEPTH));
      outValid <= (next_count != '0);
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end
endmodule
`default_nettype wire

// ===== iotg_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "iotg_regs.svh"
module iotg_monitor
  import iotg_pkg::*;
#(
  parameter bit          AUTO_IO_STIMULUS_SELECT = 1'b1,
  parameter bit          CONDENSED_IO            = 1'b0,
  parameter logic [15:0] SUPPORTED_TYPES         = 16'h001F
) (
  input wire logic                    clock,
  input wire logic                    rstn,
  input wire logic                    ireqValid,
  input wire logic                    ireqReady,
  input wire iotg_pkt_t               ireq,
  input wire logic                    treqValid,
  input wire logic                    treqReady,
  input wire iotg_pkt_t               treq,
  input wire logic                    trespValid,
  input wire logic                    trespReady,
  input wire iotg_pkt_t               tresp,
  input wire logic                    iotxValid,
  input wire logic                    userIreqReady,
  input wire logic                    userIrespValid,
  input wire logic                    userTreqValid,
  input wire logic                    mismatch,
  input wire logic [`IOTG_MISS_W-1:0] mismatchCount
);
  // ------------------------------
  // Expected target responses
  // ------------------------------
  logic [13:0] expQ [16];
  logic [3:0]  wp;
  logic [3:0]  rp;
  logic [4:0]  owed;
  wire         takeReq = treqValid && treqReady && treq.ttype inside {IOTG_NREAD, IOTG_NWRITE_R, IOTG_DOORBELL};
  wire         takeRsp = trespValid && trespReady;
  wire [1:0]   incPrio = (treq.prio == 2'h3) ? 2'h3 : treq.prio + 2'h1;
  wire [3:0]   rspType = (treq.ttype == IOTG_NREAD) ? 4'h9 : 4'h8;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wp   <= '0;
      rp   <= '0;
      owed <= '0;
    end else begin
      wp   <= wp + 4'(takeReq);
      rp   <= rp + 4'(takeRsp);
      owed <= owed + 5'(takeReq) - 5'(takeRsp);
    end
  end

  always_ff @(posedge clock) begin
    if (takeReq) expQ[wp] <= {rspType, treq.tid, incPrio};
  end

  // ------------------------------
  // Assertions
  // ------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  ireq_hold_a: assert property (ireqValid && !ireqReady |=> ireqValid && $stable(ireq))
    else $error("Stalled request changed");
  type_allowed_a: assert property (ireqValid |-> SUPPORTED_TYPES[ireq.ttype])
    else $error("Unsupported type issued");
  miss_sticky_a: assert property (mismatch |=> mismatch)
    else $error("Mismatch flag cleared");
  miss_count_a: assert property (!$stable(mismatchCount) |-> mismatch)
    else $error("Count moved without flag");
  resp_check_a: assert property (AUTO_IO_STIMULUS_SELECT |-> !userIrespValid)
    else $error("Response reached user side");
  user_bypass_a: assert property (AUTO_IO_STIMULUS_SELECT |-> !userIreqReady && !userTreqValid)
    else $error("User side not bypassed");
  no_unasked_a: assert property (trespValid |-> owed != 5'h0)
    else $error("Unasked response");
  resp_order_a: assert property (trespValid |-> tresp.tid == expQ[rp][9:2])
    else $error("Response out of order");
  resp_prio_a: assert property (trespValid |-> tresp.prio == expQ[rp][1:0])
    else $error("Response priority wrong");
  resp_kind_a: assert property (trespValid |-> tresp.ttype == expQ[rp][13:10])
    else $error("Response type wrong");
  tresp_hold_a: assert property (trespValid && !trespReady |=> trespValid && $stable(tresp))
    else $error("Stalled response changed");
  mode_sel_a: assert property (!CONDENSED_IO |-> !iotxValid)
    else $error("Condensed channel active");
endmodule

bind iotg_top iotg_monitor #(
  .AUTO_IO_STIMULUS_SELECT(AUTO_IO_STIMULUS_SELECT),
  .CONDENSED_IO(CONDENSED_IO),
  .SUPPORTED_TYPES(SUPPORTED_TYPES)
) u_iotg_monitor (
  .clock, .rstn, .ireqValid, .ireqReady, .ireq, .treqValid, .treqReady, .treq, .trespValid,
  .trespReady, .tresp, .iotxValid, .userIreqReady, .userIrespValid, .userTreqValid, .mismatch,
  .mismatchCount
);
`default_nettype wire

// ===== iotg_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module iotg_core_model
  import iotg_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       ireqValid,
  output var  logic       ireqReady,
  input  wire iotg_pkt_t  ireq,
  output var  logic       irespValid,
  input  wire logic       irespReady,
  output var  iotg_pkt_t  iresp,
  input  wire logic [3:0] gap,
  input  wire logic       corrupt
);
  iotg_pkt_t pend[$];
  iotg_pkt_t req;
  int        waited;

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ireqReady  <= 1'b0;
      irespValid <= 1'b0;
      iresp      <= '0;
      pend.delete();
      waited = 0;
    end else begin
      ireqReady <= (gap == 4'h0) || !ireqReady;
      if (ireqValid && ireqReady && ireq.ttype inside {IOTG_NREAD, IOTG_NWRITE_R, IOTG_DOORBELL})
        pend.push_back(ireq);
      if (irespValid && irespReady) begin
        irespValid <= 1'b0;
        iresp      <= ~iresp;
      end else if (!irespValid && pend.size() > 0) begin
        if (waited < gap) begin
          waited++;
        end else begin
          req = pend.pop_front();
          waited = 0;
          iresp.ttype <= (req.ttype == IOTG_NREAD) ? IOTG_RESP_DAT : IOTG_RESP_NOD;
          iresp.tid   <= req.tid ^ {7'h0, corrupt};
          iresp.prio  <= req.prio;
          iresp.addr  <= '0;
          iresp.data  <= req.data;
          irespValid  <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== iotg_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "iotg_regs.svh"
module tb
  import iotg_pkg::*;
;
  logic       clock, rstn, ireqValid, ireqReady, irespValid, irespReady, treqValid, treqReady;
  logic       trespValid, trespReady, iotxValid, iotxReady, iorxValid, iorxReady, corrupt;
  logic       userIreqValid, userIreqReady, userIrespValid, userIrespReady, userTreqValid;
  logic       userTreqReady, userTrespValid, userTrespReady, exerciseDone, mismatch;
  logic [7:0] mismatchCount;
  logic [3:0] gap;
  iotg_pkt_t  ireq, iresp, treq, tresp, iotx, iorx, userIreq, userIresp, userTreq, userTresp;
  iotg_pkt_t  rsps[$], reqs[$];
  int         err_total, cmp_count, patNext;

  iotg_top u_iotg_top (
    .clock, .rstn, .ireqValid, .ireqReady, .ireq, .irespValid, .irespReady, .iresp, .treqValid,
    .treqReady, .treq, .trespValid, .trespReady, .tresp, .iotxValid, .iotxReady, .iotx, .iorxValid,
    .iorxReady, .iorx, .userIreqValid, .userIreqReady, .userIreq, .userIrespValid, .userIrespReady,
    .userIresp, .userTreqValid, .userTreqReady, .userTreq, .userTrespValid, .userTrespReady,
    .userTresp, .exerciseDone, .mismatch, .mismatchCount
  );
  iotg_core_model u_iotg_core_model (
    .clock, .rstn, .ireqValid, .ireqReady, .ireq, .irespValid, .irespReady, .iresp, .gap, .corrupt
  );

  always #2 clock = ~clock;

  always @(negedge clock) begin
    if (trespValid && trespReady) rsps.push_back(tresp);
    if (ireqValid && ireqReady) reqs.push_back(ireq);
  end

  // ------------------------------
  // Checking and closing
  // ------------------------------
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic hang();
    err_total++;
    $display("Error at %0t: wait timed out", $time);
    give_verdict();
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic chk_rsp(input iotg_ttype_t ty, input logic [7:0] tid, input logic [1:0] pr,
                         input logic [63:0] d);
    int        k;
    iotg_pkt_t got;
    for (k = 0; k < 200 && rsps.size() == 0; k++) @(posedge clock);
    if (rsps.size() == 0) hang();
    got = rsps.pop_front();
    cmp_count++;
    if (got.ttype !== ty || got.tid !== tid || got.prio !== pr || (ty == IOTG_RESP_DAT && got.data !== d)) begin
      err_total++;
      $display("Error at %0t: bad response %0h", $time, got);
    end
  endtask

  // ------------------------------
  // Target-side drivers
  // ------------------------------
  task automatic send(input iotg_ttype_t ty, input logic [7:0] tid, input logic [1:0] pr,
                      input logic [31:0] a, input logic [63:0] d);
    int k;
    @(posedge clock);
    treqValid <= 1'b1;
    treq      <= '{ty, tid, pr, a, d};
    for (k = 0; k < 50; k++) begin
      @(negedge clock);
      if (treqReady) break;
    end
    if (k == 50) hang();
    @(posedge clock);
    treqValid <= 1'b0;
  endtask

  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic auto_run();
    int k;
    for (k = 0; k < 2000 && exerciseDone !== 1'b1; k++) @(posedge clock);
    if (k == 2000) hang();
    chk(reqs.size(), `IOTG_LIST_N);
    for (k = 0; k < reqs.size() && k < `IOTG_LIST_N; k++) begin
      chk({reqs[k].ttype, reqs[k].prio, reqs[k].addr}, {IOTG_LIST[k].ttype, IOTG_LIST[k].prio, IOTG_LIST[k].addr});
      chk(reqs[k].data, IOTG_LIST[k].data);
    end
    chk(mismatch, 1'b0);
    chk({userIreqReady, userTreqValid, userIrespValid, userTrespReady, iorxReady}, 5'h0);
  endtask

  task automatic scratch_rw();
    trespReady <= 1'b1;
    send(IOTG_NWRITE_R, 8'h03, 2'h3, 32'h0012_0028, 64'hA5A5_0000_1234_5678);
    send(IOTG_SWRITE, 8'h04, 2'h0, 32'h0012_0030, 64'h0F0F_F0F0_5555_AAAA);
    send(IOTG_NWRITE, 8'h05, 2'h1, 32'h0050_0028, 64'hDEAD_0000_0000_BEEF);
    send(IOTG_DOORBELL, 8'h06, 2'h2, 32'h0000_0000, 64'h0000_0000_0000_0001);
    send(IOTG_NREAD, 8'h07, 2'h0, 32'h0012_0028, 64'h0);
    send(IOTG_NREAD, 8'h08, 2'h1, 32'h0012_0030, 64'h0);
    send(IOTG_NREAD, 8'h09, 2'h2, 32'h0050_0028, 64'h0);
    chk_rsp(IOTG_RESP_NOD, 8'h03, 2'h3, 64'h0);
    chk_rsp(IOTG_RESP_NOD, 8'h06, 2'h3, 64'h0);
    chk_rsp(IOTG_RESP_DAT, 8'h07, 2'h1, 64'hA5A5_0000_1234_5678);
    chk_rsp(IOTG_RESP_DAT, 8'h08, 2'h2, 64'h0F0F_F0F0_5555_AAAA);
    chk_rsp(IOTG_RESP_DAT, 8'h09, 2'h3, 64'(patNext));
    patNext++;
    repeat (20) @(posedge clock);
    chk(rsps.size(), 0);
  endtask

  task automatic fill_drain();
    int        n, k;
    logic      acc;
    n = 0;
    @(posedge clock);
    trespReady <= 1'b0;
    treqValid  <= 1'b1;
    treq       <= '{IOTG_NREAD, 8'h20, 2'h0, 32'h0060_0000, 64'h0};
    for (k = 0; k < 120; k++) begin
      @(negedge clock);
      acc = treqReady;
      if (k == 40) chk(acc, 1'b0);
      @(posedge clock);
      if (k == 40) trespReady <= 1'b1;
      if (acc) begin
        n++;
        if (k > 40) break;
        treq.tid <= 8'h20 + 8'(n);
      end
    end
    if (k == 120) hang();
    treqValid <= 1'b0;
    chk(n > `IOTG_FIFO_DEPTH, 1'b1);
    for (k = 0; k < n; k++) begin
      chk_rsp(IOTG_RESP_DAT, 8'h20 + 8'(k), 2'h1, 64'(patNext));
      patNext++;
    end
  endtask

  task automatic bad_resp();
    int k;
    rstn    <= 1'b0;
    corrupt <= 1'b1;
    gap     <= 4'h0;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    for (k = 0; k < 500 && mismatch !== 1'b1; k++) @(posedge clock);
    chk(mismatch, 1'b1);
    chk(mismatchCount != 8'h00, 1'b1);
  endtask

  initial begin
    clock = 1'b0;
    rstn = 1'b0;
    treqValid = 1'b0;
    treq = '0;
    trespReady = 1'b0;
    gap = 4'h3;
    corrupt = 1'b0;
    userIreqValid = 1'b1;
    userIreq = '0;
    userIrespReady = 1'b1;
    userTreqReady = 1'b1;
    userTrespValid = 1'b1;
    userTresp = '0;
    iotxReady = 1'b1;
    iorxValid = 1'b1;
    iorx = '0;
    err_total = 0;
    cmp_count = 0;
    patNext = 0;
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    auto_run();
    scratch_rw();
    fill_drain();
    bad_resp();
    give_verdict();
  end
endmodule
`default_nettype wire
